// ---- ahb_pkg.sv ----
// Purpose: Shared constants and types for the host wait port
// Assumes: 125 MHz clock, all pins sampled synchronously
// Notes: Times are in ps so fractions of a ns stay exact
`default_nettype none
package ahb_pkg;
    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 8000;
    localparam int RD_WAIT_TURBO_PS = 40000;
    localparam int RD_WAIT_NORMAL_PS = 80000;
    localparam int WR_WAIT_DATA_PS = 36000;
    localparam int WAIT_START_MAX_PS = 8000;
    localparam int DATA_BEFORE_READY_MAX_PS = 800;
    // Least waits round up
    localparam int RD_WAIT_TURBO_CYC =
        (RD_WAIT_TURBO_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RD_WAIT_NORMAL_CYC =
        (RD_WAIT_NORMAL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WR_WAIT_DATA_CYC =
        (WR_WAIT_DATA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Longest time to wait start rounds down, at least one cycle
    localparam int WAIT_START_CYC =
        (WAIT_START_MAX_PS / CLK_PERIOD_PS) < 1 ? 1 :
        (WAIT_START_MAX_PS / CLK_PERIOD_PS);
    localparam int CNT_W = 8;
    // ****************************************************************
    // Bus shape and decode
    // ****************************************************************
    localparam int ADDR_W = 15;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam logic [14:0] BANK_SEL_ADDR = 15'h0007;
    localparam logic [14:0] QUEUE_DATA_ADDR = 15'h0001;
    localparam logic [31:0] BANK_SEL_RST = 32'h0000_0000;
    localparam logic TURBO_RST = 1'b0;
    // Access target
    typedef enum logic [1:0] {
        AHB_TGT_OTHER = 2'b00,
        AHB_TGT_BANK = 2'b01,
        AHB_TGT_QUEUE = 2'b10
    } ahb_tgt_e;
endpackage
`default_nettype wire

// ---- ahb_if.sv ----
// Purpose: Pins between host and the wait port device
// Assumes: Data bus shared; resolved from both enables
// Notes: Device drives read data, host drives write data
`default_nettype none
interface ahb_if;
    import ahb_pkg::*;
    logic address_latch_strobe_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic data_port_select_n;
    logic address_qualifier;
    logic [ADDR_W-1:0] host_address_lines;
    logic [BE_W-1:0] byte_lane_enables_n;
    logic async_wait_ready;
    logic [DATA_W-1:0] host_data_out;
    logic host_data_oe;
    logic [DATA_W-1:0] dev_data_out;
    logic dev_data_oe;
    logic [DATA_W-1:0] data_bus;
    // Wire level from the two enables
    assign data_bus = dev_data_oe ? dev_data_out :
        (host_data_oe ? host_data_out : '0);
    modport dev (
        input address_latch_strobe_n, read_strobe_n, write_strobe_n,
        input data_port_select_n, address_qualifier, host_address_lines,
        input byte_lane_enables_n, host_data_out, data_bus,
        output async_wait_ready, dev_data_out, dev_data_oe
    );
    modport host (
        output address_latch_strobe_n, read_strobe_n, write_strobe_n,
        output data_port_select_n, address_qualifier, host_address_lines,
        output byte_lane_enables_n, host_data_out, host_data_oe,
        input async_wait_ready, data_bus
    );
endinterface
`default_nettype wire

// ---- ahb_dev.sv ----
// Purpose: Device end: decodes host strobes, stretches with wait
// Assumes: Strobes synchronous to clk; one access in flight
// Notes: Notes on behaviour are listed below
//
// Notes on behaviour
// - Host holds strobe low while ready low
// - Next access may start during write wait
// - Turbo: bank read no wait, queue 40ns
// - Normal: queue read waits 80ns first
// - Bank write no wait, queue write 36ns
// - Read wait starts within 8ns of strobe
// - Write wait starts within 8ns after strobe
// - Read data valid by ready rise
// - Latch address fields on strobe rising edge
// - Tied strobe: host holds address stable
// - Data select spans whole strobe
`default_nettype none
module ahb_dev
    import ahb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    // Configuration
    input wire logic turbo_mode_cfg,
    // Host pins
    ahb_if.dev pins,
    // User side register file
    output logic [ADDR_W-1:0] user_addr,
    output logic [BE_W-1:0] user_be_n,
    output logic user_wr,
    output logic user_rd,
    output logic [DATA_W-1:0] user_wdata,
    input wire logic [DATA_W-1:0] user_rdata
);
    typedef enum logic [1:0] {
        AHB_D_IDLE = 2'b00,
        AHB_D_RWAIT = 2'b01,
        AHB_D_RHOLD = 2'b10,
        AHB_D_WWAIT = 2'b11
    } ahb_dst_e;
    typedef struct packed {
        ahb_dst_e st;
        logic [CNT_W-1:0] cnt;
        logic turbo;
        logic ads_prev;
        logic rd_prev;
        logic wr_prev;
        logic [ADDR_W-1:0] lat_addr;
        logic lat_qual;
        logic [BE_W-1:0] lat_be;
        logic [ADDR_W-1:0] addr;
        logic [BE_W-1:0] be;
        logic wr_p;
        logic rd_p;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic rdata_oe;
        logic ready;
        ahb_tgt_e tgt;
    } ahb_dstate_s;

    ahb_dstate_s s_q, s_d;
    logic [ADDR_W-1:0] eff_addr;
    logic eff_qual;
    logic [BE_W-1:0] eff_be;
    logic sel;
    ahb_tgt_e tgt_now;

    // Refuse widths that the decode and counter cannot serve
    if (ADDR_W != 15 || BE_W != 4 || CNT_W < 4) begin : g_bad_width
        $error("ahb_dev: unsupported widths");
    end

    // ****************************************************************
    // Address path
    // ****************************************************************
    // Latched fields used once the strobe has been pulsed
    always_comb begin
        eff_addr = pins.address_latch_strobe_n ? s_q.lat_addr :
            pins.host_address_lines;
        eff_qual = pins.address_latch_strobe_n ? s_q.lat_qual :
            pins.address_qualifier;
        eff_be = pins.address_latch_strobe_n ? s_q.lat_be :
            pins.byte_lane_enables_n;
        sel = !eff_qual || !pins.data_port_select_n;
        if (!pins.data_port_select_n || eff_addr == QUEUE_DATA_ADDR) begin
            tgt_now = AHB_TGT_QUEUE;
        end else if (eff_addr == BANK_SEL_ADDR) begin
            tgt_now = AHB_TGT_BANK;
        end else begin
            tgt_now = AHB_TGT_OTHER;
        end
    end

    // ****************************************************************
    // Access sequencer
    // ****************************************************************
    // Next state for strobes, wait counter and data
    always_comb begin
        s_d = s_q;
        s_d.wr_p = 1'b0;
        s_d.rd_p = 1'b0;
        s_d.ads_prev = pins.address_latch_strobe_n;
        s_d.rd_prev = pins.read_strobe_n;
        s_d.wr_prev = pins.write_strobe_n;
        s_d.turbo = turbo_mode_cfg;
        // Capture on rising edge of the address strobe
        if (pins.address_latch_strobe_n && !s_q.ads_prev) begin
            s_d.lat_addr = pins.host_address_lines;
            s_d.lat_qual = pins.address_qualifier;
            s_d.lat_be = pins.byte_lane_enables_n;
        end
        case (s_q.st)
            AHB_D_IDLE, AHB_D_RHOLD, AHB_D_WWAIT: begin
                if (s_q.st == AHB_D_WWAIT) begin
                    if (s_q.cnt <= 1) begin
                        s_d.ready = 1'b1;
                        s_d.st = AHB_D_IDLE;
                    end else begin
                        s_d.cnt = s_q.cnt - 1'b1;
                    end
                end
                // Fetch a no-wait read once its address has settled
                if (s_q.st == AHB_D_RHOLD && s_q.rd_p) begin
                    s_d.rdata = user_rdata;
                    s_d.rdata_oe = 1'b1;
                end
                if (s_q.st == AHB_D_RHOLD && pins.read_strobe_n) begin
                    s_d.rdata_oe = 1'b0;
                    s_d.st = AHB_D_IDLE;
                end
                // New read accepted even during write wait
                if (!pins.read_strobe_n && s_q.rd_prev && sel) begin
                    s_d.addr = eff_addr;
                    s_d.be = eff_be;
                    s_d.tgt = tgt_now;
                    if (tgt_now == AHB_TGT_QUEUE) begin
                        s_d.ready = 1'b0;
                        s_d.rdata_oe = 1'b0;
                        s_d.cnt = s_q.turbo ?
                            CNT_W'(RD_WAIT_TURBO_CYC) :
                            CNT_W'(RD_WAIT_NORMAL_CYC);
                        s_d.st = AHB_D_RWAIT;
                    end else begin
                        s_d.rd_p = 1'b1;
                        s_d.rdata_oe = 1'b0;
                        s_d.st = AHB_D_RHOLD;
                    end
                end
                // Write completes at strobe release
                if (pins.write_strobe_n && !s_q.wr_prev && sel) begin
                    s_d.addr = eff_addr;
                    s_d.be = eff_be;
                    s_d.wdata = pins.data_bus;
                    s_d.wr_p = 1'b1;
                    if (tgt_now == AHB_TGT_QUEUE) begin
                        s_d.ready = 1'b0;
                        s_d.cnt = CNT_W'(WR_WAIT_DATA_CYC);
                        s_d.st = AHB_D_WWAIT;
                    end
                end
            end
            AHB_D_RWAIT: begin
                if (s_q.cnt == CNT_W'(2)) begin
                    s_d.rd_p = 1'b1;
                end
                if (s_q.cnt == 1) begin
                    // Data driven with ready release
                    s_d.rdata = user_rdata;
                    s_d.rdata_oe = 1'b1;
                    s_d.ready = 1'b1;
                    s_d.st = AHB_D_RHOLD;
                end else begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end
            end
            default: begin
                s_d.st = AHB_D_IDLE;
            end
        endcase
    end

    // State register with clock enable
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.st <= AHB_D_IDLE;
            s_q.turbo <= TURBO_RST;
            s_q.ads_prev <= 1'b1;
            s_q.rd_prev <= 1'b1;
            s_q.wr_prev <= 1'b1;
            s_q.lat_qual <= 1'b1;
            s_q.lat_be <= '1;
            s_q.be <= '1;
            s_q.rdata <= BANK_SEL_RST;
            s_q.ready <= 1'b1;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state
    assign pins.async_wait_ready = s_q.ready;
    assign pins.dev_data_out = s_q.rdata;
    assign pins.dev_data_oe = s_q.rdata_oe;
    assign user_addr = s_q.addr;
    assign user_be_n = s_q.be;
    assign user_wr = s_q.wr_p;
    assign user_rd = s_q.rd_p;
    assign user_wdata = s_q.wdata;
endmodule
`default_nettype wire

// ---- ahb_host.sv ----
// Purpose: Host end: drives strobes, honours the wait output
// Assumes: One request at a time from the user side
// Notes: Address strobe style selected by a user input
`default_nettype none
module ahb_host
    import ahb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    // Pins to the device
    ahb_if.host pins,
    // User request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic use_addr_strobe,
    input wire logic use_data_select,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [BE_W-1:0] req_be_n,
    input wire logic [DATA_W-1:0] req_wdata,
    // User answer
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata
);
    typedef enum logic [2:0] {
        AHB_H_IDLE = 3'b000,
        AHB_H_ADS = 3'b001,
        AHB_H_STRB = 3'b010,
        AHB_H_WAIT = 3'b011,
        AHB_H_END = 3'b100,
        AHB_H_SET1 = 3'b101,
        AHB_H_SET2 = 3'b110
    } ahb_hst_e;
    typedef struct packed {
        ahb_hst_e st;
        logic wr;
        logic dsel;
        logic ads_n;
        logic rd_n;
        logic wr_n;
        logic dcs_n;
        logic qual;
        logic [ADDR_W-1:0] addr;
        logic [BE_W-1:0] be;
        logic [DATA_W-1:0] wdata;
        logic doe;
        logic rdy;
        logic rv;
        logic [DATA_W-1:0] rdata;
    } ahb_hstate_s;
    ahb_hstate_s s_q, s_d;

    // ****************************************************************
    // Host sequencer
    // ****************************************************************
    // Address first, strobe next, hold through wait
    always_comb begin
        s_d = s_q;
        s_d.rv = 1'b0;
        case (s_q.st)
            AHB_H_IDLE: begin
                if (req_valid) begin
                    s_d.wr = req_write;
                    s_d.dsel = use_data_select;
                    s_d.addr = req_addr;
                    s_d.be = req_be_n;
                    s_d.qual = use_data_select;
                    s_d.wdata = req_wdata;
                    s_d.doe = req_write;
                    s_d.rdy = 1'b0;
                    s_d.dcs_n = !use_data_select;
                    // Low is transparent, or opens the latch pulse
                    s_d.ads_n = 1'b0;
                    s_d.st = use_addr_strobe ? AHB_H_ADS : AHB_H_STRB;
                end
            end
            AHB_H_ADS: begin
                s_d.ads_n = 1'b1;
                s_d.st = AHB_H_STRB;
            end
            AHB_H_STRB: begin
                // Strobe may start while a write wait is pending
                s_d.rd_n = s_q.wr;
                s_d.wr_n = !s_q.wr;
                s_d.st = AHB_H_SET1;
            end
            AHB_H_SET1: begin
                // Device answers one edge after it sees the strobe
                s_d.st = AHB_H_SET2;
            end
            AHB_H_SET2: begin
                // No-wait read data lands one edge later still
                s_d.st = AHB_H_WAIT;
            end
            AHB_H_WAIT: begin
                // Keep strobe low until ready is high
                if (pins.async_wait_ready) begin
                    if (!s_q.wr) begin
                        s_d.rdata = pins.data_bus;
                        s_d.rv = 1'b1;
                    end
                    s_d.rd_n = 1'b1;
                    s_d.wr_n = 1'b1;
                    s_d.st = AHB_H_END;
                end
            end
            AHB_H_END: begin
                s_d.doe = 1'b0;
                s_d.dcs_n = 1'b1;
                s_d.rdy = 1'b1;
                s_d.st = AHB_H_IDLE;
            end
            default: begin
                s_d.st = AHB_H_IDLE;
            end
        endcase
    end

    // State register with clock enable
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.st <= AHB_H_IDLE;
            s_q.ads_n <= 1'b0;
            s_q.rd_n <= 1'b1;
            s_q.wr_n <= 1'b1;
            s_q.dcs_n <= 1'b1;
            s_q.qual <= 1'b0;
            s_q.be <= '1;
            s_q.rdy <= 1'b1;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // Pins and answer from state
    assign pins.address_latch_strobe_n = s_q.ads_n;
    assign pins.read_strobe_n = s_q.rd_n;
    assign pins.write_strobe_n = s_q.wr_n;
    assign pins.data_port_select_n = s_q.dcs_n;
    assign pins.address_qualifier = s_q.qual;
    assign pins.host_address_lines = s_q.addr;
    assign pins.byte_lane_enables_n = s_q.be;
    assign pins.host_data_out = s_q.wdata;
    assign pins.host_data_oe = s_q.doe;
    assign req_ready = s_q.rdy;
    assign rsp_valid = s_q.rv;
    assign rsp_rdata = s_q.rdata;
endmodule
`default_nettype wire

// ---- ahb_checker.sv ----
// Purpose: Assertions on the pins between host and wait port
// Assumes: One clock domain, reset async active low
// Notes: Queue target is data select low or address 1
`default_nettype none
module ahb_checker
    import ahb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Host pins
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic data_port_select_n,
    input wire logic address_qualifier,
    input wire logic [ADDR_W-1:0] host_address_lines,
    // Device pins
    input wire logic async_wait_ready,
    input wire logic dev_data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Decode and wait length counter
    // ****************************************************************
    logic queue_hit;
    logic bank_hit;
    logic [3:0] low_cnt_q;
    // Target of the access on the pins
    assign queue_hit = !data_port_select_n ||
        (!address_qualifier && host_address_lines == QUEUE_DATA_ADDR);
    assign bank_hit = data_port_select_n && !address_qualifier &&
        host_address_lines == BANK_SEL_ADDR;
    // Counts cycles of ready low, saturating
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            low_cnt_q <= 4'h0;
        end else if (async_wait_ready) begin
            low_cnt_q <= 4'h0;
        end else if (low_cnt_q != 4'hf) begin
            low_cnt_q <= low_cnt_q + 4'h1;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // ****************************************************************
    // Properties
    // ****************************************************************
    a_read_wait_start: assert property (
        $fell(read_strobe_n) && queue_hit |=> !async_wait_ready)
        else $error("ready not low after queue read start");
    a_read_wait_min: assert property (
        $fell(read_strobe_n) && queue_hit |=> !async_wait_ready [*5])
        else $error("queue read wait shorter than five cycles");
    a_write_wait_len: assert property (
        $rose(write_strobe_n) && queue_hit |=> !async_wait_ready [*5])
        else $error("queue write wait missing or short");
    a_bank_read_free: assert property (
        $fell(read_strobe_n) && bank_hit && async_wait_ready
        |=> async_wait_ready)
        else $error("bank read caused a wait");
    a_bank_write_free: assert property (
        $rose(write_strobe_n) && bank_hit && async_wait_ready
        |=> async_wait_ready)
        else $error("bank write caused a wait");
    a_data_at_ready: assert property (
        $rose(async_wait_ready) && !read_strobe_n |-> dev_data_oe)
        else $error("read data not driven when ready rose");
    a_host_holds_read: assert property (
        !async_wait_ready && !read_strobe_n |=> !read_strobe_n)
        else $error("read strobe released during wait");
    a_wait_bounded: assert property (
        low_cnt_q <= 4'ha)
        else $error("ready held low over ten cycles");
    a_data_release: assert property (
        $rose(read_strobe_n) |=> !dev_data_oe)
        else $error("read data still driven after strobe end");
endmodule
`default_nettype wire

// ---- test_async_host_bus_wait_port.sv ----
// Purpose: Self-checking bench of host end against device end
// Assumes: Inputs change at the falling clock edge
// Notes: Wait length is counted in cycles of ready low
`default_nettype none
module test_async_host_bus_wait_port;
    import ahb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic clk, rstn, turbo, req_valid, req_write, use_as, use_ds;
    logic [ADDR_W-1:0] req_addr, user_addr, seen_addr;
    logic [BE_W-1:0] req_be_n, user_be_n;
    logic [DATA_W-1:0] req_wdata, rsp_rdata, user_wdata, user_rdata;
    logic [DATA_W-1:0] seen_data, got_rd;
    logic req_ready, rsp_valid, user_wr, user_rd;
    int err_count, comparisons, low_cycles, rd_pulses;
    ahb_if ahb_if_inst();
    ahb_dev ahb_dev_inst(.clk(clk), .rstn(rstn), .clk_en(1'b1),
        .turbo_mode_cfg(turbo), .pins(ahb_if_inst.dev),
        .user_addr(user_addr), .user_be_n(user_be_n), .user_wr(user_wr),
        .user_rd(user_rd), .user_wdata(user_wdata),
        .user_rdata(user_rdata));
    ahb_host ahb_host_inst(.clk(clk), .rstn(rstn), .clk_en(1'b1),
        .pins(ahb_if_inst.host), .req_valid(req_valid),
        .req_write(req_write), .use_addr_strobe(use_as),
        .use_data_select(use_ds), .req_addr(req_addr),
        .req_be_n(req_be_n), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata));
    ahb_checker ahb_checker_inst(.clk(clk), .rstn(rstn),
        .read_strobe_n(ahb_if_inst.read_strobe_n),
        .write_strobe_n(ahb_if_inst.write_strobe_n),
        .data_port_select_n(ahb_if_inst.data_port_select_n),
        .address_qualifier(ahb_if_inst.address_qualifier),
        .host_address_lines(ahb_if_inst.host_address_lines),
        .async_wait_ready(ahb_if_inst.async_wait_ready),
        .dev_data_oe(ahb_if_inst.dev_data_oe));
    // Register file answer follows the address
    assign user_rdata = {17'h00000, user_addr} ^ 32'h5a5a_0000;
    // Clock, write monitor and read pulse count
    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (user_wr === 1'b1) begin
            seen_addr <= user_addr;
            seen_data <= user_wdata;
        end
        if (user_rd === 1'b1) begin
            rd_pulses <= rd_pulses + 1;
        end
    end
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic complete_run;
        if (err_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One request; counts ready low until idle, and on to ready if drain
    task automatic run_req(input logic wr, input logic as_en,
        input logic ds_en, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, input bit drain);
        int n;
        @(negedge clk);
        req_valid = 1'b1;
        req_write = wr;
        use_as = as_en;
        use_ds = ds_en;
        req_addr = a;
        req_wdata = d;
        @(negedge clk);
        req_valid = 1'b0;
        low_cycles = 0;
        for (n = 0; n < 100 && req_ready !== 1'b1; n++) begin
            if (rsp_valid === 1'b1) got_rd = rsp_rdata;
            if (ahb_if_inst.async_wait_ready !== 1'b1) low_cycles++;
            @(negedge clk);
        end
        for (; drain && n < 100 && ahb_if_inst.async_wait_ready !== 1'b1;
            n++) begin
            low_cycles++;
            @(negedge clk);
        end
        if (n >= 100) begin
            err_count++;
            complete_run();
        end
    endtask
    task automatic t_read_normal;
        run_req(1'b0, 1'b0, 1'b0, 15'h0001, 32'h0000_0000, 1'b1);
        check_val(32'(low_cycles), 32'h0000_000a);
        check_val(got_rd, 32'h5a5a_0001);
    endtask
    task automatic t_read_turbo;
        turbo = 1'b1;
        run_req(1'b0, 1'b0, 1'b1, 15'h0001, 32'h0000_0000, 1'b1);
        check_val(32'(low_cycles), 32'h0000_0005);
        check_val(got_rd, 32'h5a5a_0001);
    endtask
    task automatic t_bank_read;
        int rd0;
        rd0 = rd_pulses;
        run_req(1'b0, 1'b1, 1'b0, 15'h0007, 32'h0000_0000, 1'b1);
        check_val(32'(rd_pulses - rd0), 32'h0000_0001);
        check_val(32'(low_cycles), 32'h0000_0000);
        check_val(got_rd, 32'h5a5a_0007);
    endtask
    task automatic t_queue_write;
        req_be_n = 4'ha;
        run_req(1'b1, 1'b0, 1'b0, 15'h0001, 32'hcafe_0001, 1'b1);
        check_val({28'h0000000, user_be_n}, 32'h0000_000a);
        check_val(32'(low_cycles), 32'h0000_0005);
        check_val(seen_data, 32'hcafe_0001);
        check_val({17'h00000, seen_addr}, 32'h0000_0001);
    endtask
    task automatic t_back_to_back;
        run_req(1'b1, 1'b1, 1'b0, 15'h0001, 32'h1234_5678, 1'b0);
        run_req(1'b1, 1'b1, 1'b0, 15'h0007, 32'h8765_4321, 1'b1);
        // Write pulse is seen by the monitor one edge after the end
        @(negedge clk);
        check_val(seen_data, 32'h8765_4321);
        check_val({17'h00000, seen_addr}, 32'h0000_0007);
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        turbo = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        use_as = 1'b0;
        use_ds = 1'b0;
        req_addr = '0;
        req_be_n = 4'h0;
        req_wdata = '0;
        err_count = 0;
        comparisons = 0;
        rd_pulses = 0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        t_read_normal();
        t_read_turbo();
        t_bank_read();
        t_queue_write();
        t_back_to_back();
        complete_run();
    end
endmodule
`default_nettype wire
